// ### rtl/sia_pkg.sv
// Purpose: shared constants and types of the signed adder block
// Assumes: 32-bit classic wishbone register port, byte addresses
// Notes:   all offsets are byte addresses of aligned 32-bit words

package sia_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_FLAGS    = 8'h04;
  localparam logic [7:0] OFF_S1K      = 8'h08;
  localparam logic [7:0] OFF_S2K      = 8'h0C;
  localparam logic [7:0] OFF_ADDR     = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_EN   = 8'h18;
  localparam logic [7:0] OFF_IRQ_CLR  = 8'h1C;
  // data word window 0x40..0x7C, one 16-bit word per bus word
  localparam logic [1:0] MEM_WIN_TAG  = 2'h1;
  localparam int         MEM_WORD_LSB = 2;
  localparam int         MEM_WIN_LSB  = 6;

  // ---------------------------------------------------------------
  // field layouts and masks
  // ---------------------------------------------------------------
  localparam int CTRL_RUN   = 0;
  localparam int CTRL_FORM  = 1;
  localparam int CTRL_FLOAT = 3;
  localparam int CTRL_S1K   = 4;
  localparam int CTRL_S2K   = 5;
  localparam logic [31:0] CTRL_MASK = 32'h0000_003F;
  localparam int ADDR_S1_LSB = 0;
  localparam int ADDR_S2_LSB = 8;
  localparam int ADDR_D_LSB  = 16;
  localparam logic [31:0] ADDR_MASK = 32'h000F_0F0F;
  localparam int FLG_ZERO  = 0;
  localparam int FLG_UNDER = 1;
  localparam int FLG_OVER  = 2;
  localparam int FLG_BUSY  = 3;
  localparam int FLG_EXEC  = 4;
  localparam int IRQ_W     = 3;
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_UNDER = 1;
  localparam int IRQ_OVER  = 2;

  // ---------------------------------------------------------------
  // forms of the addition
  // ---------------------------------------------------------------
  localparam logic [1:0] FORM_PULSE16 = 2'h0;
  localparam logic [1:0] FORM_CONT32  = 2'h1;
  localparam logic [1:0] FORM_PULSE32 = 2'h2;
  localparam logic [1:0] FORM_CONT16  = 2'h3;

  // ---------------------------------------------------------------
  // data memory and number ranges
  // ---------------------------------------------------------------
  localparam int MEM_AW = 4;
  localparam int MEM_DEPTH = 16;
  localparam int WORD_W = 16;
  localparam logic [33:0] LIM16_MAX = 34'h0_0000_7FFF;
  localparam logic [33:0] LIM16_MIN = 34'h3_FFFF_8000;
  localparam logic [33:0] LIM32_MAX = 34'h0_7FFF_FFFF;
  localparam logic [33:0] LIM32_MIN = 34'h3_8000_0000;
  localparam logic [7:0]  FLT_ALIGN_MAX = 8'h19;
  localparam logic [7:0]  FLT_I2F_EXP   = 8'h9E;
  localparam logic [9:0]  FLT_EXP_MAX   = 10'h0FF;

  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_RD0, ST_RD1, ST_RD2, ST_RD3, ST_LAST, ST_CALC, ST_WR_LO, ST_WR_HI
  } sia_state_type;

endpackage : sia_pkg

// ### rtl/sia_word_mem.sv
// Purpose: small single-port store of 16-bit data words
// Assumes: one access per clock, read data valid the cycle after
// Notes:   the array itself has no reset, only the read register

`timescale 1ns/100ps

module sia_word_mem
  import sia_pkg::*;
(
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_resetn,
  // access port
  input  wire logic              i_we,
  input  wire logic [MEM_AW-1:0] i_addr,
  input  wire logic [WORD_W-1:0] i_wdata,
  output logic      [WORD_W-1:0] o_rdata
);

  logic [WORD_W-1:0] words [MEM_DEPTH];

  // write port, old value shows on read in the same cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_we) begin
      words[i_addr] <= i_wdata;
    end
  end

  // registered read
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 16'h0000;
    end else begin
      o_rdata <= words[i_addr];
    end
  end

endmodule : sia_word_mem

// ### rtl/sia_adder.sv
// Purpose: signed adder with zero, underflow and overflow flags
// Assumes: classic wishbone slave, 20 MHz reference clock
// Notes:   operands come from constants or the 16-word data store
//
// Our own choices: the address map and the Wishbone interface to the registers.

`timescale 1ns/100ps

module sia_adder
  import sia_pkg::*;
(
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  // wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // status outputs
  output logic             o_irq,
  output logic             o_exec_state
);

  // -------------------------------------------------------------
  // helper functions
  // -------------------------------------------------------------

  // byte-lane merge for register writes
  function automatic logic [31:0] sel_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : sel_merge

  // signed integer to single float, truncating low bits
  function automatic logic [31:0] int_to_flt(input logic [31:0] v);
    logic [31:0] m;
    logic [7:0]  e;
    m = v[31] ? (~v + 32'h0000_0001) : v;
    e = FLT_I2F_EXP;
    for (int i = 0; i < 31; i++) begin
      if (!m[31]) begin
        m = m << 1;
        e = e - 8'h01;
      end
    end
    return (v == 32'h0000_0000) ? 32'h0000_0000 : {v[31], e, m[30:8]};
  endfunction : int_to_flt

  // float add, returns {overflow, underflow, result}; truncates,
  // a denormal larger operand gives zero, a denormal smaller one is still added, to keep the datapath small
  function automatic logic [33:0] flt_add(input logic [31:0] x,
                                          input logic [31:0] y);
    logic [31:0] p;
    logic [31:0] q;
    logic [25:0] mp;
    logic [25:0] mq;
    logic [25:0] s;
    logic [9:0]  e;
    logic [7:0]  d;
    p = x;
    q = y;
    if (y[30:0] > x[30:0]) begin
      p = y;
      q = x;
    end
    mp = {2'b00, p[30:23] != 8'h00, p[22:0]};
    mq = {2'b00, q[30:23] != 8'h00, q[22:0]};
    d  = p[30:23] - q[30:23];
    mq = (d > FLT_ALIGN_MAX) ? 26'h000_0000 : (mq >> d);
    s  = (p[31] == q[31]) ? (mp + mq) : (mp - mq);
    e  = {2'b00, p[30:23]};
    if (s[24]) begin
      s = s >> 1;
      e = e + 10'h001;
    end
    for (int i = 0; i < 24; i++) begin
      if (s != 26'h000_0000 && !s[23]) begin
        s = s << 1;
        e = e - 10'h001;
      end
    end
    if (s == 26'h000_0000 || p[30:23] == 8'h00) begin
      return 34'h0_0000_0000;
    end else if (e[9] || e == 10'h000) begin
      return {2'b01, 32'h0000_0000};
    end else if (e >= FLT_EXP_MAX) begin
      return {2'b10, 32'h0000_0000};
    end
    return {2'b00, p[31], e[7:0], s[22:0]};
  endfunction : flt_add

  // -------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------
  sia_state_type     state;
  logic [31:0]       ctrl;
  logic [31:0]       k1;
  logic [31:0]       k2;
  logic [31:0]       addr_cfg;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_en;
  logic              zero_result_flag;
  logic              underflow_flag;
  logic              overflow_flag;
  logic              run_q;
  logic              pulse_pend;
  logic              mem_phase;
  logic [MEM_AW-1:0] cur_s1w;
  logic [MEM_AW-1:0] cur_s2w;
  logic [MEM_AW-1:0] cur_dw;
  logic              cur_wide;
  logic              cur_float;
  logic              cur_s1k;
  logic              cur_s2k;
  logic [31:0]       rd_s1;
  logic [31:0]       rd_s2;
  logic [31:0]       res;
  logic              mem_we;
  logic [MEM_AW-1:0] mem_addr;
  logic [WORD_W-1:0] mem_wdata;
  logic [WORD_W-1:0] mem_rdata;
  logic [31:0]       reg_rdata;
  logic [31:0]       op_a;
  logic [31:0]       op_b;
  logic [33:0]       sum;
  logic [33:0]       fres;
  logic [31:0]       calc_res;
  logic              calc_ovf;
  logic              calc_unf;
  logic              calc_zero;
  logic [IRQ_W-1:0]  irq_set;
  logic [IRQ_W-1:0]  irq_clr;

  // -------------------------------------------------------------
  // bus decode and triggers
  // -------------------------------------------------------------
  logic              bus_req;
  logic              is_mem;
  logic              wr_reg;
  logic              bus_mem_go;
  logic              run;
  logic [1:0]        form;
  logic              is_pulse;
  logic              start;
  logic              done_ev;

  assign bus_req    = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign is_mem     = (i_wb_adr[7:MEM_WIN_LSB] == MEM_WIN_TAG);
  assign wr_reg     = bus_req & i_wb_we & ~is_mem;
  // bus gets the store only between operations
  assign bus_mem_go = bus_req & is_mem & (state == ST_IDLE) & ~mem_phase;
  assign run        = ctrl[CTRL_RUN];
  assign form       = ctrl[CTRL_FORM +: 2];
  assign is_pulse   = (form == FORM_PULSE16) | (form == FORM_PULSE32);
  assign start      = (state == ST_IDLE) & ~(bus_req & is_mem) & (pulse_pend | (run & ~is_pulse));
  assign done_ev    = (state == ST_WR_HI) | ((state == ST_WR_LO) & ~cur_wide);

  // -------------------------------------------------------------
  // data store
  // -------------------------------------------------------------
  sia_word_mem u_mem (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_we      (mem_we),
    .i_addr    (mem_addr),
    .i_wdata   (mem_wdata),
    .o_rdata   (mem_rdata)
  );

  // store port mux; partial-lane bus writes are dropped
  always_comb begin
    mem_addr  = i_wb_adr[MEM_WORD_LSB +: MEM_AW];
    mem_we    = 1'b0;
    mem_wdata = i_wb_dat[15:0];
    unique case (state)
      ST_IDLE:  mem_we = bus_mem_go & i_wb_we & (&i_wb_sel[1:0]);
      ST_RD0:   mem_addr = cur_s1w;
      ST_RD1:   mem_addr = cur_s1w + 4'h1;
      ST_RD2:   mem_addr = cur_s2w;
      ST_RD3:   mem_addr = cur_s2w + 4'h1;
      ST_LAST:  mem_addr = cur_dw;
      ST_CALC:  mem_addr = cur_dw;
      ST_WR_LO: begin
        mem_addr  = cur_dw;
        mem_we    = 1'b1;
        mem_wdata = res[15:0];
      end
      ST_WR_HI: begin
        mem_addr  = cur_dw + 4'h1;
        mem_we    = 1'b1;
        mem_wdata = res[31:16];
      end
    endcase
  end

  // -------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------

  // reads all finish before the first write
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE:  if (start) state <= ST_RD0;
        ST_RD0:   state <= ST_RD1;
        ST_RD1:   state <= ST_RD2;
        ST_RD2:   state <= ST_RD3;
        ST_RD3:   state <= ST_LAST;
        ST_LAST:  state <= ST_CALC;
        ST_CALC:  state <= ST_WR_LO;
        ST_WR_LO: state <= cur_wide ? ST_WR_HI : ST_IDLE;
        ST_WR_HI: state <= ST_IDLE;
      endcase
    end
  end

  // addresses and mode frozen at start; k1 and k2 are read live at the add, so mid-run writes to them count
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cur_s1w   <= 4'h0;
      cur_s2w   <= 4'h0;
      cur_dw    <= 4'h0;
      cur_wide  <= 1'b0;
      cur_float <= 1'b0;
      cur_s1k   <= 1'b0;
      cur_s2k   <= 1'b0;
    end else if (start) begin
      cur_s1w   <= addr_cfg[ADDR_S1_LSB +: MEM_AW];
      cur_s2w   <= addr_cfg[ADDR_S2_LSB +: MEM_AW];
      cur_dw    <= addr_cfg[ADDR_D_LSB +: MEM_AW];
      // width from form, float is always a pair
      cur_wide  <= (form == FORM_CONT32) | (form == FORM_PULSE32) | ctrl[CTRL_FLOAT];
      cur_float <= ctrl[CTRL_FLOAT];
      cur_s1k   <= ctrl[CTRL_S1K];
      cur_s2k   <= ctrl[CTRL_S2K];
    end
  end

  // edge of run arms one pulse add
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      run_q      <= 1'b0;
      pulse_pend <= 1'b0;
    end else begin
      run_q <= run;
      if (run & ~run_q & is_pulse) begin
        pulse_pend <= 1'b1;
      end else if (start) begin
        pulse_pend <= 1'b0;
      end
    end
  end

  // capture halves, read data lags address a cycle
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_s1 <= 32'h0000_0000;
      rd_s2 <= 32'h0000_0000;
    end else begin
      if (state == ST_RD1) rd_s1[15:0]  <= mem_rdata;
      if (state == ST_RD2) rd_s1[31:16] <= mem_rdata;
      if (state == ST_RD3) rd_s2[15:0]  <= mem_rdata;
      if (state == ST_LAST) rd_s2[31:16] <= mem_rdata;
    end
  end

  // -------------------------------------------------------------
  // arithmetic
  // -------------------------------------------------------------
  always_comb begin
    op_a     = cur_s1k ? k1 : rd_s1;
    op_b     = cur_s2k ? k2 : rd_s2;
    sum      = 34'h0_0000_0000;
    fres     = 34'h0_0000_0000;
    calc_res = 32'h0000_0000;
    calc_ovf = 1'b0;
    calc_unf = 1'b0;
    if (cur_float) begin
      // constants to float, then float add
      if (cur_s1k) op_a = int_to_flt(k1);
      if (cur_s2k) op_b = int_to_flt(k2);
      // stored words used as float bits
      fres     = flt_add(op_a, op_b);
      calc_ovf = fres[33];
      calc_unf = fres[32];
      calc_res = fres[31:0];
    end else begin
      if (!cur_wide) begin
        op_a = {{16{op_a[15]}}, op_a[15:0]};
        op_b = {{16{op_b[15]}}, op_b[15:0]};
      end
      sum = {{2{op_a[31]}}, op_a} + {{2{op_b[31]}}, op_b};
      calc_ovf = $signed(sum) > $signed(cur_wide ? LIM32_MAX : LIM16_MAX);
      calc_unf = $signed(sum) < $signed(cur_wide ? LIM32_MIN : LIM16_MIN);
      calc_res = (calc_ovf | calc_unf) ? 32'h0000_0000 : sum[31:0];
    end
    calc_zero = cur_wide ? (calc_res == 32'h0000_0000) : (calc_res[15:0] == 16'h0000);
  end

  // result and all three flags on every add
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      res              <= 32'h0000_0000;
      zero_result_flag <= 1'b0;
      underflow_flag   <= 1'b0;
      overflow_flag    <= 1'b0;
    end else if (state == ST_CALC) begin
      res              <= calc_res;
      zero_result_flag <= calc_zero;
      underflow_flag   <= calc_unf;
      overflow_flag    <= calc_ovf;
    end
  end

  // -------------------------------------------------------------
  // registers and interrupt
  // -------------------------------------------------------------

  // software-written registers, reserved bits masked off
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl     <= 32'h0000_0000;
      k1       <= 32'h0000_0000;
      k2       <= 32'h0000_0000;
      addr_cfg <= 32'h0000_0000;
      irq_en   <= 3'h0;
    end else if (wr_reg) begin
      case (i_wb_adr)
        OFF_CTRL:   ctrl     <= sel_merge(ctrl, i_wb_dat, i_wb_sel) & CTRL_MASK;
        OFF_S1K:    k1       <= sel_merge(k1, i_wb_dat, i_wb_sel);
        OFF_S2K:    k2       <= sel_merge(k2, i_wb_dat, i_wb_sel);
        OFF_ADDR:   addr_cfg <= sel_merge(addr_cfg, i_wb_dat, i_wb_sel) & ADDR_MASK;
        OFF_IRQ_EN: if (i_wb_sel[0]) irq_en <= i_wb_dat[IRQ_W-1:0];
        default:    ;
      endcase
    end
  end

  // sticky events; a set in the clear cycle survives
  always_comb begin
    irq_set            = '0;
    irq_set[IRQ_DONE]  = done_ev;
    irq_set[IRQ_UNDER] = (state == ST_CALC) & calc_unf;
    irq_set[IRQ_OVER]  = (state == ST_CALC) & calc_ovf;
    irq_clr            = (wr_reg && i_wb_adr == OFF_IRQ_CLR && i_wb_sel[0]) ? i_wb_dat[IRQ_W-1:0] : '0;
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_stat <= 3'h0;
      o_irq    <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      o_irq    <= |(irq_stat & irq_en);
    end
  end

  // read mux, unmapped words read zero
  always_comb begin
    reg_rdata = 32'h0000_0000;
    case (i_wb_adr)
      OFF_CTRL:     reg_rdata = ctrl;
      OFF_S1K:      reg_rdata = k1;
      OFF_S2K:      reg_rdata = k2;
      OFF_ADDR:     reg_rdata = addr_cfg;
      OFF_IRQ_STAT: reg_rdata[IRQ_W-1:0] = irq_stat;
      OFF_IRQ_EN:   reg_rdata[IRQ_W-1:0] = irq_en;
      OFF_FLAGS: begin
        reg_rdata[FLG_ZERO]  = zero_result_flag;
        reg_rdata[FLG_UNDER] = underflow_flag;
        reg_rdata[FLG_OVER]  = overflow_flag;
        reg_rdata[FLG_BUSY]  = (state != ST_IDLE);
        reg_rdata[FLG_EXEC]  = o_exec_state;
      end
      default:      reg_rdata = 32'h0000_0000;
    endcase
  end

  // ack: registers next edge, store reads one edge later
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wb_ack  <= 1'b0;
      o_wb_dat  <= 32'h0000_0000;
      mem_phase <= 1'b0;
    end else begin
      o_wb_ack <= 1'b0;
      if (mem_phase) begin
        o_wb_ack  <= 1'b1;
        o_wb_dat  <= {16'h0000, mem_rdata};
        mem_phase <= 1'b0;
      end else if (bus_req & ~is_mem) begin
        o_wb_ack <= 1'b1;
        o_wb_dat <= i_wb_we ? 32'h0000_0000 : reg_rdata;
      end else if (bus_mem_go) begin
        o_wb_ack  <= i_wb_we;
        mem_phase <= ~i_wb_we;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_exec_state <= 1'b0;
    end else begin
      o_exec_state <= run;
    end
  end

endmodule : sia_adder

// ### tb/sia_checker.sv
// Purpose: port checks of the signed adder
// Assumes: one clock, async active low reset
// Notes:   sees top ports only
`timescale 1ns/100ps
module sia_checker
  import sia_pkg::*;
(
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  // bus request
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  // answers and status
  input  wire logic [31:0] o_wb_dat,
  input  wire logic        o_wb_ack,
  input  wire logic        o_irq,
  input  wire logic        o_exec_state
);
  // --------------------
  // properties
  // --------------------
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  // pending request and store window decode
  wire req = i_wb_cyc & i_wb_stb & !o_wb_ack;
  wire win = i_wb_adr[7:6] == MEM_WIN_TAG;
  wire rda = o_wb_ack & !i_wb_we;

  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  reg_ack_a: assert property (req && !win |=> o_wb_ack)
    else $error("register ack late");
  // store waits for a running add, so allow its length
  win_ack_a: assert property (req && win |-> ##[1:14] o_wb_ack)
    else $error("store ack missing");
  ack_cause_a: assert property (o_wb_ack |-> $past(i_wb_cyc & i_wb_stb))
    else $error("ack without request");
  wr_zero_a: assert property (o_wb_ack && i_wb_we && !win |-> o_wb_dat == 32'h0)
    else $error("register write returned data");
  // store writes leave the last read data in place
  win_wr_hold_a: assert property (o_wb_ack && i_wb_we && win |-> $stable(o_wb_dat))
    else $error("store write changed read data");
  unmapped_a: assert property (rda && (i_wb_adr[7] || i_wb_adr[7:5] == 3'h1) |-> o_wb_dat == 32'h0)
    else $error("unmapped read not zero");
  win_high_a: assert property (rda && win |-> o_wb_dat[31:16] == 16'h0)
    else $error("store read upper half set");
  flag_mix_a: assert property (rda && i_wb_adr == OFF_FLAGS |->
    !(o_wb_dat[FLG_UNDER] & o_wb_dat[FLG_OVER]) && (!(o_wb_dat[FLG_UNDER] | o_wb_dat[FLG_OVER]) || o_wb_dat[FLG_ZERO]))
    else $error("flags inconsistent");
  exec_cause_a: assert property (o_exec_state != $past(o_exec_state) |->
    $past(o_wb_ack && i_wb_we && i_wb_adr == OFF_CTRL))
    else $error("exec state moved without control write");
  irq_fall_a: assert property ($fell(o_irq) |-> $past(o_wb_ack && i_wb_we))
    else $error("irq dropped without write");
endmodule : sia_checker

// ### tb/sia_seq_model.sv
// Purpose: sequencer model, classic wishbone master
// Assumes: called right after a rising edge
// Notes:   one idle cycle follows every transfer
`timescale 1ns/100ps
module sia_seq_model (
  // clock
  input  wire logic        i_ref_clk,
  // master side
  output logic             o_cyc,
  output logic             o_stb,
  output logic             o_we,
  output logic [7:0]       o_adr,
  output logic [3:0]       o_sel,
  output logic [31:0]      o_dat,
  input  wire logic        i_ack,
  input  wire logic [31:0] i_dat
);
  // idle bus at time zero
  initial begin
    o_cyc = 1'b0;
    o_stb = 1'b0;
    o_we  = 1'b0;
    o_adr = 8'h00;
    o_sel = 4'hF;
    o_dat = 32'h0;
  end
  // hold the request until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    o_cyc <= 1'b1;
    o_stb <= 1'b1;
    o_we  <= w;
    o_adr <= a;
    o_dat <= d;
    do @(posedge i_ref_clk); while (!i_ack);
    r = i_dat;
    o_cyc <= 1'b0;
    o_stb <= 1'b0;
    // released data no longer shows the last value
    o_dat <= ~d;
    @(posedge i_ref_clk);
  endtask : xfer
endmodule : sia_seq_model

// ### tb/testbench.sv
// Purpose: self-checking bench of the signed adder
// Assumes: 20 MHz clock, seed 18
// Notes:   expected sums computed in the bench, by ref_add or inline, never by the design
`timescale 1ns/100ps
module testbench;
  import sia_pkg::*;
  logic        i_ref_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic        cyc, stb, we, ack, irq, exe;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q, v, a, b;
  logic [35:0] e;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          cycles = 0;
  logic [7:0]  ra [4] = '{OFF_CTRL, OFF_FLAGS, OFF_IRQ_STAT, 8'h24};
  logic [31:0] ca [6] = '{32'h7FFF, 32'h8000, 32'h5, 32'h7FFF_FFFF, 32'h8000_0000, 32'h157C};
  logic [31:0] cb [6] = '{32'h1, 32'hFFFF, 32'hFFF8, 32'h1, 32'hFFFF_FFFF, 32'hFFFF_DEA4};
  always #25 i_ref_clk = ~i_ref_clk;
  sia_adder dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .o_irq(irq), .o_exec_state(exe));
  sia_seq_model seq (.i_ref_clk(i_ref_clk), .o_cyc(cyc), .o_stb(stb), .o_we(we), .o_adr(adr),
    .o_sel(sel), .o_dat(wdat), .i_ack(ack), .i_dat(rdat));
  // hang guard, far above the expected run length
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic results;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    seq.xfer(1'b1, ad, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    seq.xfer(1'b0, ad, 32'h0, q);
  endtask : rd
  // clear status, start, poll the sticky done bit
  task automatic go(input logic [31:0] c);
    wr(OFF_IRQ_CLR, 32'h7);
    chk("irq clear", 32'h0, {31'h0, irq});
    wr(OFF_CTRL, c);
    chk("exec", {31'h0, c[CTRL_RUN]}, {31'h0, exe});
    q = 32'h0;
    while (q[IRQ_DONE] !== 1'b1) rd(OFF_IRQ_STAT);
  endtask : go
  // {over, under, zero, result}; out of range stores zero
  function automatic logic [35:0] ref_add(input logic w, input logic [31:0] x, input logic [31:0] y);
    longint s, hi;
    logic o, u;
    logic [31:0] r;
    hi = w ? 2147483647 : 32767;
    s = w ? longint'($signed(x)) + longint'($signed(y)) : longint'($signed(x[15:0])) + longint'($signed(y[15:0]));
    o = s > hi;
    u = s < -hi - 1;
    r = (o | u) ? 32'h0 : (w ? s[31:0] : {16'h0, s[15:0]});
    return {1'b0, o, u, r == 32'h0, r};
  endfunction : ref_add
  task automatic do_add(input logic [1:0] f, input logic [31:0] x, input logic [31:0] y, input logic en);
    wr(8'h40, {16'h0, x[15:0]});
    wr(8'h44, {16'h0, x[31:16]});
    wr(8'h48, {16'h0, y[15:0]});
    wr(8'h4C, {16'h0, y[31:16]});
    wr(OFF_ADDR, 32'h0004_0200);
    wr(OFF_IRQ_EN, {31'h0, en});
    go({29'h0, f, 1'b1});
    chk("irq", {31'h0, en}, {31'h0, irq});
    wr(OFF_CTRL, 32'h0);
    e = ref_add(f == FORM_PULSE32, x, y);
    rd(8'h50);
    chk("sum low", {16'h0, e[15:0]}, q);
    rd(8'h54);
    if (f == FORM_PULSE32) chk("sum high", {16'h0, e[31:16]}, q);
    rd(OFF_FLAGS);
    chk("flags", {29'h0, e[34:32]}, {29'h0, q[2:0]});
  endtask : do_add
  // --------------------
  // scenarios
  // --------------------
  initial begin
    void'($urandom(18));
    repeat (10) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    foreach (ra[i]) begin
      rd(ra[i]);
      chk("reset read", 32'h0, q);
    end
    for (int i = 0; i < 30; i++) begin
      a = (i < 6) ? ca[i] : $urandom;
      b = (i < 6) ? cb[i] : $urandom;
      do_add((i < 3 || (i >= 6 && !i[0])) ? FORM_PULSE16 : FORM_PULSE32, a, b, i[1]);
    end
    // one pulse add while run stays on, then continuous adds accumulate
    v = $urandom_range(1000);
    wr(8'h58, v);
    wr(OFF_S2K, 32'd7);
    wr(OFF_ADDR, 32'h0006_0006);
    go(32'h21);
    repeat (40) @(posedge i_ref_clk);
    wr(OFF_CTRL, 32'h0);
    rd(8'h58);
    chk("pulse once", v + 32'd7, q);
    wr(8'h58, 32'h0);
    wr(OFF_S2K, 32'd1);
    go(32'h27);
    repeat (40) @(posedge i_ref_clk);
    wr(OFF_CTRL, 32'h0);
    repeat (12) @(posedge i_ref_clk);
    rd(8'h58);
    chk("accumulate", 32'h1, {31'h0, q > 32'd4});
    // continuous pair, constant adds only into the high word, then one float pulse add of the two constants
    wr(8'h58, 32'h0);
    wr(8'h5C, 32'h0);
    wr(OFF_S1K, 32'h0001_0000);
    wr(OFF_ADDR, 32'h0006_0600);
    go(32'h13);
    repeat (40) @(posedge i_ref_clk);
    wr(OFF_CTRL, 32'h0);
    repeat (12) @(posedge i_ref_clk);
    rd(8'h5C);
    chk("pair accumulate", 32'h1, {31'h0, q > 32'd4});
    rd(8'h58);
    chk("pair low", 32'h0, q);
    wr(OFF_S1K, 32'd1);
    wr(OFF_ADDR, 32'h0004_0000);
    go(32'h3D);
    wr(OFF_CTRL, 32'h0);
    rd(8'h54);
    chk("float high", 32'h4000, q);
    rd(8'h50);
    chk("float low", 32'h0, q);
    results();
  end
endmodule : testbench
bind sia_adder sia_checker chk_i (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat),
  .o_wb_ack(o_wb_ack), .o_irq(o_irq), .o_exec_state(o_exec_state));
